// >>> conv_ctrl_pkg.sv
package conv_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [6:0]  ADDR_CONVERSION_CONTROL = 7'h4c;
	localparam logic [6:0]  ADDR_RATE_FAULT_CONFIG  = 7'h4d;
	localparam logic [15:0] RESET_CONVERSION_CONTROL = 16'h2000;
	localparam logic [15:0] RESET_RATE_FAULT_CONFIG  = 16'h0070;

	// ----------------------------------------------------------------
	// Field positions, conversion_control
	// ----------------------------------------------------------------
	localparam int BIT_CONVERSION_MODE = 13;
	localparam int BIT_SOFT_START      = 12;
	localparam int BIT_SYNC_DAC_LOAD   = 11;
	localparam int BIT_ADC_REF_INT     = 10;
	localparam int BIT_ALARM_PIN_EN    = 9;
	localparam int BIT_DATA_AVAIL      = 7;
	localparam int BIT_GLOBAL_ALARM    = 6;

	// ----------------------------------------------------------------
	// Field positions, rate_and_fault_count_config
	// ----------------------------------------------------------------
	localparam int RATE_LSB       = 8;
	localparam int CH_FAULT_LSB   = 5;
	localparam int TEMP_FAULT_LSB = 3;
	localparam logic [1:0] RESET_SAMPLE_RATE   = 2'h0;
	localparam logic [2:0] RESET_CH_FAULT      = 3'h3;
	localparam logic [1:0] RESET_TEMP_FAULT    = 2'h2;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_ADC_CH = 16;
	localparam int NUM_DAC_CH = 12;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 10;
	localparam int BASE_SAMPLE_NS     = 2000;
	localparam int DAV_PULSE_NS       = 1000;
	localparam int BASE_SAMPLE_CYCLES = BASE_SAMPLE_NS / CLK_PERIOD_NS;
	localparam int DAV_PULSE_CYCLES   = DAV_PULSE_NS / CLK_PERIOD_NS;

	typedef enum logic [0:0] {
		SEQ_IDLE,
		SEQ_RUN
	} seq_state_t;

endpackage

// >>> conv_ctrl.sv
`timescale 1ns/1ps

// What this block does
// R01: Bit 13 selects single-pass or continuous, resets 1
// R02: Single-pass converts enabled channels once, then idles
// R03: Continuous wraps to first channel until mode cleared
// R04: Writing bit 12 starts conversion, bit self-clears
// R05: Bit 11 loads written sync-mode DAC channels only
// R06: Latch updates at once; load bit self-clears
// R07: Bit 10 selects internal or external reference
// R08: Bit 9 enables alarm pin, resets 0
// R09: Bit 7 set after single-pass finishes, else 0
// R10: Single-pass data pin is inverse of flag
// R11: Continuous mode pulses data pin low 1 us
// R12: Flag clears on data read, start, write 0
// R13: Bit 6 sticky OR of alarms, cleared by status read
// R14: Second register resets 0070h with three fields
// R15: Rate field picks 500, 250, 125, 62.5 kSPS
// R16: Channel fault count codes 1 to 256
// R17: Reserved bits read 0; read-only bits ignore writes
module conv_ctrl
	import conv_ctrl_pkg::*;
(
	input  wire logic                  i_mclk,
	input  wire logic                  i_rst_n,
	input  wire logic [6:0]            i_reg_addr,
	input  wire logic                  i_reg_wr,
	input  wire logic                  i_reg_rd,
	input  wire logic [15:0]           i_reg_wdata,
	output logic      [15:0]           o_reg_rdata,
	input  wire logic [NUM_ADC_CH-1:0] i_chan_enable,
	input  wire logic                  i_adc_data_rd,
	input  wire logic                  i_status_rd,
	input  wire logic [15:0]           i_alarm_bits,
	input  wire logic                  i_alarm_active,
	input  wire logic [NUM_DAC_CH-1:0] i_dac_sync_update_select,
	input  wire logic [NUM_DAC_CH-1:0] i_dac_data_written,
	output logic      [NUM_DAC_CH-1:0] o_dac_latch_load,
	output logic                       o_sample_strobe,
	output logic      [3:0]            o_mux_chan,
	output logic                       o_busy,
	output logic                       o_int_ref_buf_en,
	output logic                       o_alarm_n,
	output logic                       o_data_available_pin_n,
	output logic      [1:0]            o_sample_rate_select,
	output logic      [8:0]            o_channel_fault_limit,
	output logic      [3:0]            o_temp_fault_limit
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                  conversion_mode_select;
	logic                  soft_convert_start;
	logic                  sync_dac_load;
	logic                  adc_ref_int;
	logic                  alarm_pin_en;
	logic [1:0]            sample_rate_select;
	logic [2:0]            channel_fault_count;
	logic [1:0]            temp_fault_count;
	logic                  next_conversion_mode_select;
	logic                  next_soft_convert_start;
	logic                  next_sync_dac_load;
	logic                  next_adc_ref_int;
	logic                  next_alarm_pin_en;
	logic [1:0]            next_sample_rate_select;
	logic [2:0]            next_channel_fault_count;
	logic [1:0]            next_temp_fault_count;

	seq_state_t            state;
	seq_state_t            next_state;
	logic [3:0]            chan;
	logic [3:0]            next_chan;
	logic [10:0]           tick_cnt;
	logic [10:0]           next_tick_cnt;
	logic                  strobe;
	logic                  next_strobe;
	logic [6:0]            dav_cnt;
	logic [6:0]            next_dav_cnt;

	logic                  data_available_flag;
	logic                  next_data_available_flag;
	logic                  global_alarm_flag;
	logic                  next_global_alarm_flag;
	logic [NUM_DAC_CH-1:0] dac_pending;
	logic [NUM_DAC_CH-1:0] next_dac_pending;
	logic [NUM_DAC_CH-1:0] latch_load;
	logic [NUM_DAC_CH-1:0] next_latch_load;
	logic [15:0]           rdata;
	logic [15:0]           next_rdata;

	logic                  wr_ctrl;
	logic                  wr_cfg;
	logic                  start_now;
	logic                  seq_done;
	logic                  cont_wrap;
	logic [10:0]           period;
	logic [15:0]           ctrl_view;
	logic [15:0]           cfg_view;

	assign wr_ctrl = i_reg_wr && (i_reg_addr == ADDR_CONVERSION_CONTROL);
	assign wr_cfg  = i_reg_wr && (i_reg_addr == ADDR_RATE_FAULT_CONFIG);

	// Start is taken the cycle after the bit is written
	assign start_now = soft_convert_start; // see R04

	// Sample period doubles for each rate step
	assign period = 11'(BASE_SAMPLE_CYCLES) << sample_rate_select; // see R15

	// Lowest enabled channel above the given one; flag says none remain
	function automatic logic [4:0] next_enabled(input logic [3:0] from,
	                                             input logic first);
		logic [4:0] res;
		res = 5'h10;
		for (int i = NUM_ADC_CH - 1; i >= 0; i--) begin
			if (i_chan_enable[i] && (first || (4'(i) > from))) begin
				res = 5'(i);
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_comb begin
		next_conversion_mode_select = conversion_mode_select;
		next_soft_convert_start     = soft_convert_start & ~start_now; // see R04
		next_sync_dac_load          = 1'b0; // see R06
		next_adc_ref_int            = adc_ref_int;
		next_alarm_pin_en           = alarm_pin_en;
		next_sample_rate_select     = sample_rate_select;
		next_channel_fault_count    = channel_fault_count;
		next_temp_fault_count       = temp_fault_count;
		if (wr_ctrl) begin
			next_conversion_mode_select = i_reg_wdata[BIT_CONVERSION_MODE]; // see R01
			next_adc_ref_int            = i_reg_wdata[BIT_ADC_REF_INT];     // see R07
			next_alarm_pin_en           = i_reg_wdata[BIT_ALARM_PIN_EN];    // see R08
			if (i_reg_wdata[BIT_SOFT_START]) begin
				next_soft_convert_start = 1'b1; // see R04
			end
			next_sync_dac_load = i_reg_wdata[BIT_SYNC_DAC_LOAD]; // see R05
		end
		if (wr_cfg) begin
			next_sample_rate_select  = i_reg_wdata[RATE_LSB+:2];       // see R15
			next_channel_fault_count = i_reg_wdata[CH_FAULT_LSB+:3];   // see R16
			next_temp_fault_count    = i_reg_wdata[TEMP_FAULT_LSB+:2]; // see R14
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			conversion_mode_select <= RESET_CONVERSION_CONTROL[BIT_CONVERSION_MODE]; // see R01
			soft_convert_start     <= 1'b0;
			sync_dac_load          <= 1'b0;
			adc_ref_int            <= 1'b0;
			alarm_pin_en           <= 1'b0; // see R08
			sample_rate_select     <= RESET_SAMPLE_RATE; // see R14
			channel_fault_count    <= RESET_CH_FAULT;
			temp_fault_count       <= RESET_TEMP_FAULT;
		end else begin
			conversion_mode_select <= next_conversion_mode_select;
			soft_convert_start     <= next_soft_convert_start;
			sync_dac_load          <= next_sync_dac_load;
			adc_ref_int            <= next_adc_ref_int;
			alarm_pin_en           <= next_alarm_pin_en;
			sample_rate_select     <= next_sample_rate_select;
			channel_fault_count    <= next_channel_fault_count;
			temp_fault_count       <= next_temp_fault_count;
		end
	end

	// ----------------------------------------------------------------
	// Channel sequencer
	// ----------------------------------------------------------------
	// One channel per sample period; a start while running restarts the pass
	always_comb begin
		logic [4:0] nxt;
		nxt           = next_enabled(chan, 1'b0);
		next_state    = state;
		next_chan     = chan;
		next_tick_cnt = tick_cnt;
		next_strobe   = 1'b0;
		seq_done      = 1'b0;
		cont_wrap     = 1'b0;
		if (start_now) begin
			nxt = next_enabled(4'h0, 1'b1);
			next_tick_cnt = 11'h000;
			if (nxt[4]) begin
				next_state = SEQ_IDLE; // nothing enabled: finish at once
				seq_done   = 1'b1;
			end else begin
				next_state = SEQ_RUN;
				next_chan  = nxt[3:0];
			end
		end else begin
			case (state)
				SEQ_IDLE: begin
					next_tick_cnt = 11'h000;
				end
				SEQ_RUN: begin
					if (tick_cnt >= period - 11'h001) begin
						next_tick_cnt = 11'h000;
						if (!nxt[4]) begin
							next_chan = nxt[3:0]; // see R02
						end else if (conversion_mode_select) begin
							nxt       = next_enabled(4'h0, 1'b1);
							cont_wrap = 1'b1; // see R11
							if (nxt[4]) begin
								next_state = SEQ_IDLE;
							end else begin
								next_chan = nxt[3:0]; // see R03
							end
						end else begin
							next_state = SEQ_IDLE; // see R02
							seq_done   = 1'b1;
						end
					end else begin
						next_tick_cnt = tick_cnt + 11'h001;
						// Strobe in the period's last cycle, while the mux still holds it
						next_strobe   = (tick_cnt == period - 11'h002); // see R02
					end
				end
				default: begin
					next_state = SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state    <= SEQ_IDLE;
			chan     <= 4'h0;
			tick_cnt <= 11'h000;
			strobe   <= 1'b0;
		end else begin
			state    <= next_state;
			chan     <= next_chan;
			tick_cnt <= next_tick_cnt;
			strobe   <= next_strobe;
		end
	end

	// ----------------------------------------------------------------
	// Data-available and alarm flags
	// ----------------------------------------------------------------
	// Sets are applied last so an event in a clearing cycle survives
	always_comb begin
		next_data_available_flag = data_available_flag;
		next_global_alarm_flag   = global_alarm_flag;
		next_dav_cnt             = (dav_cnt != 7'h00) ? dav_cnt - 7'h01 : 7'h00;
		if (i_adc_data_rd || start_now ||
		    (wr_ctrl && !i_reg_wdata[BIT_DATA_AVAIL])) begin
			next_data_available_flag = 1'b0; // see R12
		end
		if (seq_done && !conversion_mode_select) begin
			next_data_available_flag = 1'b1; // see R09
		end
		if (cont_wrap) begin
			next_dav_cnt = 7'(DAV_PULSE_CYCLES); // see R11
		end
		if (i_status_rd) begin
			next_global_alarm_flag = 1'b0; // see R13
		end
		if (|i_alarm_bits) begin
			next_global_alarm_flag = 1'b1; // see R13
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_available_flag <= 1'b0;
			global_alarm_flag   <= 1'b0;
			dav_cnt             <= 7'h00;
		end else begin
			data_available_flag <= next_data_available_flag;
			global_alarm_flag   <= next_global_alarm_flag;
			dav_cnt             <= next_dav_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Synchronous DAC load
	// ----------------------------------------------------------------
	// Only channels written since the last load and in sync mode move
	always_comb begin
		next_latch_load  = {NUM_DAC_CH{1'b0}};
		next_dac_pending = dac_pending;
		if (sync_dac_load) begin
			next_latch_load  = dac_pending & i_dac_sync_update_select; // see R05
			next_dac_pending = dac_pending & ~i_dac_sync_update_select;
		end
		next_dac_pending = next_dac_pending | i_dac_data_written; // see R05
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dac_pending <= {NUM_DAC_CH{1'b0}};
			latch_load  <= {NUM_DAC_CH{1'b0}};
		end else begin
			dac_pending <= next_dac_pending;
			latch_load  <= next_latch_load; // see R06
		end
	end

	// ----------------------------------------------------------------
	// Register readback
	// ----------------------------------------------------------------
	// Reserved bits stay zero; flag is masked to 0 in continuous mode
	always_comb begin
		ctrl_view = 16'h0000; // see R17
		ctrl_view[BIT_CONVERSION_MODE] = conversion_mode_select;
		ctrl_view[BIT_SOFT_START]      = soft_convert_start;
		ctrl_view[BIT_SYNC_DAC_LOAD]   = sync_dac_load;
		ctrl_view[BIT_ADC_REF_INT]     = adc_ref_int;
		ctrl_view[BIT_ALARM_PIN_EN]    = alarm_pin_en;
		ctrl_view[BIT_DATA_AVAIL]      = data_available_flag & ~conversion_mode_select; // see R09
		ctrl_view[BIT_GLOBAL_ALARM]    = global_alarm_flag;
		cfg_view = 16'h0000;
		cfg_view[RATE_LSB+:2]       = sample_rate_select;
		cfg_view[CH_FAULT_LSB+:3]   = channel_fault_count;
		cfg_view[TEMP_FAULT_LSB+:2] = temp_fault_count;
		next_rdata = rdata;
		if (i_reg_rd) begin
			case (i_reg_addr)
				ADDR_CONVERSION_CONTROL: next_rdata = ctrl_view;
				ADDR_RATE_FAULT_CONFIG:  next_rdata = cfg_view;
				default:                 next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_reg_rdata      = rdata;
	assign o_dac_latch_load = latch_load;
	assign o_sample_strobe  = strobe;
	assign o_mux_chan       = chan;
	assign o_busy           = (state == SEQ_RUN);
	assign o_int_ref_buf_en = adc_ref_int; // see R07
	assign o_alarm_n        = ~(alarm_pin_en & i_alarm_active); // see R08
	assign o_sample_rate_select = sample_rate_select;
	assign o_temp_fault_limit   = 4'h1 << temp_fault_count;

	// Code 0 means one sample, others 4 doubling upward
	assign o_channel_fault_limit = (channel_fault_count == 3'h0) ? 9'h001 :
	                               (9'h002 << channel_fault_count); // see R16

	// Pin low while flag set (single pass) or during the pulse (continuous)
	assign o_data_available_pin_n = conversion_mode_select ? (dav_cnt == 7'h00) :
	                                ~data_available_flag; // see R10

endmodule // conv_ctrl

// >>> conv_ctrl_chk.sv
`timescale 1ns/1ps
module conv_ctrl_chk
	import conv_ctrl_pkg::*;
(
	input wire logic                  i_mclk,
	input wire logic                  i_rst_n,
	input wire logic [6:0]            i_reg_addr,
	input wire logic                  i_reg_wr,
	input wire logic                  i_reg_rd,
	input wire logic [15:0]           i_reg_wdata,
	input wire logic [15:0]           o_reg_rdata,
	input wire logic                  i_alarm_active,
	input wire logic [NUM_ADC_CH-1:0] i_chan_enable,
	input wire logic [NUM_DAC_CH-1:0] i_dac_sync_update_select,
	input wire logic [NUM_DAC_CH-1:0] o_dac_latch_load,
	input wire logic                  o_sample_strobe,
	input wire logic                  o_busy,
	input wire logic                  o_int_ref_buf_en,
	input wire logic                  o_alarm_n,
	input wire logic                  o_data_available_pin_n,
	input wire logic [1:0]            o_sample_rate_select
);
	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	logic       mode_q;
	logic [7:0] low_cnt;
	logic       wr_ctl;
	logic       wr_cfg;
	assign wr_ctl = i_reg_wr && (i_reg_addr == ADDR_CONVERSION_CONTROL);
	assign wr_cfg = i_reg_wr && (i_reg_addr == ADDR_RATE_FAULT_CONFIG);

	// Shadow of the mode bit; length of the running low stretch on the data pin
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q  <= 1'b1;
			low_cnt <= 8'h00;
		end else begin
			if (wr_ctl)
				mode_q <= i_reg_wdata[BIT_CONVERSION_MODE];
			low_cnt <= o_data_available_pin_n ? 8'h00 : low_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	a_start_busy:
	assert property (wr_ctl && i_reg_wdata[BIT_SOFT_START] && |i_chan_enable |-> ##2 o_busy)
		else $error("no busy");
	a_strobe_gap:
	assert property (o_sample_strobe |=> (!o_sample_strobe)[*8]) else $error("strobe gap");
	a_load_masked:
	assert property (|o_dac_latch_load |-> (o_dac_latch_load & ~i_dac_sync_update_select) == '0)
		else $error("load mask");
	a_ref_follows:
	assert property (wr_ctl |=> o_int_ref_buf_en == $past(i_reg_wdata[BIT_ADC_REF_INT]))
		else $error("reference select");
	a_alarm_gate:
	assert property (!i_alarm_active |-> o_alarm_n) else $error("alarm pin");
	a_rate_follows:
	assert property (wr_cfg |=> o_sample_rate_select == $past(i_reg_wdata[RATE_LSB +: 2]))
		else $error("rate field");
	// Only whole pulses seen after a settled continuous mode are judged
	a_pulse_len:
	assert property ($rose(o_data_available_pin_n) && mode_q && $past(mode_q, 120)
		|-> low_cnt == 8'(DAV_PULSE_CYCLES)) else $error("pulse length");
	a_unmapped_zero:
	assert property (i_reg_rd && i_reg_addr != ADDR_CONVERSION_CONTROL
		&& i_reg_addr != ADDR_RATE_FAULT_CONFIG |=> o_reg_rdata == 16'h0000)
		else $error("unmapped read");

	c_start: cover property (wr_ctl && i_reg_wdata[BIT_SOFT_START]);
	c_load: cover property (|o_dac_latch_load);
	c_pulse: cover property ($rose(o_data_available_pin_n) && mode_q);
endmodule // conv_ctrl_chk

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
	input  wire logic        i_mclk,
	input  wire logic [15:0] i_rdata,
	output logic      [6:0]  o_addr,
	output logic             o_wr,
	output logic             o_rd,
	output logic      [15:0] o_wdata
);
	// ----------------------------------------------------------------
	// Register access from the controller side
	// ----------------------------------------------------------------
	initial begin
		o_addr  = 7'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
		o_wdata = 16'h0000;
	end

	// Strobe spans one rising edge; released data is scrambled, not kept
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge i_mclk);
		o_addr  = a;
		o_wdata = d;
		o_wr    = 1'b1;
		@(negedge i_mclk);
		o_wr    = 1'b0;
		o_wdata = ~d;
	endtask

	// Read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(negedge i_mclk);
		o_addr = a;
		o_rd   = 1'b1;
		@(negedge i_mclk);
		o_rd = 1'b0;
		d    = i_rdata;
	endtask
endmodule // host_model

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module tb
	import conv_ctrl_pkg::*;
;
	localparam logic [6:0] CTL = ADDR_CONVERSION_CONTROL;
	// Decoded fault limits per code, lowest code in the lowest slot
	localparam logic [71:0] CH_LIM   = {9'h100, 9'h080, 9'h040, 9'h020,
	                                    9'h010, 9'h008, 9'h004, 9'h001};
	localparam logic [15:0] TEMP_LIM = 16'h8421;
	logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_reg_wr, i_reg_rd, o_sample_strobe, o_busy;
	logic        i_adc_data_rd = 1'b0, i_status_rd = 1'b0, i_alarm_active = 1'b0;
	logic        o_int_ref_buf_en, o_alarm_n, o_data_available_pin_n;
	logic [6:0]  i_reg_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata, i_chan_enable = 16'h0001, i_alarm_bits = 16'h0000;
	logic [11:0] i_dac_sync_update_select = 12'h000, i_dac_data_written = 12'h000;
	logic [11:0] o_dac_latch_load;
	logic [3:0]  o_mux_chan, o_temp_fault_limit;
	logic [1:0]  o_sample_rate_select;
	logic [8:0]  o_channel_fault_limit;
	int          miscompares = 0, n_tests = 0, cycles = 0;

	conv_ctrl uut (.i_mclk, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
		.o_reg_rdata, .i_chan_enable, .i_adc_data_rd, .i_status_rd, .i_alarm_bits,
		.i_alarm_active, .i_dac_sync_update_select, .i_dac_data_written, .o_dac_latch_load,
		.o_sample_strobe, .o_mux_chan, .o_busy, .o_int_ref_buf_en, .o_alarm_n,
		.o_data_available_pin_n, .o_sample_rate_select, .o_channel_fault_limit,
		.o_temp_fault_limit);
	host_model host (.i_mclk, .i_rdata(o_reg_rdata), .o_addr(i_reg_addr), .o_wr(i_reg_wr),
		.o_rd(i_reg_rd), .o_wdata(i_reg_wdata));

	// ----------------------------------------------------------------
	// Clock, hang guard, verdict
	// ----------------------------------------------------------------
	always #5 i_mclk = ~i_mclk;
	// The whole run needs well under 5000 cycles
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Helpers: single-pass start, status read pulse, strobe log of one pass
	task automatic go(input logic [15:0] en);
		i_chan_enable = en;
		host.wr(CTL, 16'h1000);
		repeat (2) @(negedge i_mclk);
	endtask
	task automatic status_read;
		i_status_rd = 1'b1;
		@(negedge i_mclk);
		i_status_rd = 1'b0;
	endtask
	task automatic run_pass(output int n, output logic [3:0] f, output logic [3:0] l);
		n = 0;
		for (int k = 0; k < 4000 && o_busy; k++) begin
			@(negedge i_mclk);
			if (o_sample_strobe) begin
				if (n == 0) f = o_mux_chan;
				l = o_mux_chan;
				n++;
			end
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [15:0] d;
		host.rd(CTL, d);
		`CHK(d, RESET_CONVERSION_CONTROL)
		host.rd(ADDR_RATE_FAULT_CONFIG, d);
		`CHK(d, RESET_RATE_FAULT_CONFIG)
		host.rd(7'h10, d);
		`CHK(d, 16'h0000)
		`CHK({o_alarm_n, o_data_available_pin_n, o_channel_fault_limit}, 11'h610)
	endtask
	task automatic t_ref_alarm;
		host.wr(CTL, 16'h2600);
		i_alarm_active = 1'b1;
		#1;
		`CHK({o_int_ref_buf_en, o_alarm_n}, 2'b10)
		host.wr(CTL, 16'h2000);
		`CHK({o_int_ref_buf_en, o_alarm_n}, 2'b01)
		i_alarm_active = 1'b0;
	endtask
	// Reserved ones are written too and must not read back
	task automatic t_config;
		logic [15:0] d;
		logic [2:0]  c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			host.wr(ADDR_RATE_FAULT_CONFIG, {6'h3f, c[1:0], c, c[1:0], 3'h7});
			host.rd(ADDR_RATE_FAULT_CONFIG, d);
			`CHK(d, {6'h00, c[1:0], c, c[1:0], 3'h0})
			`CHK(o_sample_rate_select, c[1:0])
			`CHK(o_channel_fault_limit, CH_LIM[9*i +: 9])
			`CHK(o_temp_fault_limit, TEMP_LIM[4*(i%4) +: 4])
		end
		host.wr(ADDR_RATE_FAULT_CONFIG, RESET_RATE_FAULT_CONFIG);
	endtask
	task automatic t_single;
		logic [15:0] d;
		logic [3:0]  f, l;
		int          n;
		go(16'h8005);
		host.rd(CTL, d);
		`CHK({o_busy, d[12]}, 2'b10)
		run_pass(n, f, l);
		@(negedge i_mclk);
		`CHK({n[3:0], f, l, o_busy}, 13'h061e)
		`CHK(o_data_available_pin_n, 1'b0)
		status_read();
		host.rd(CTL, d);
		`CHK(d[7], 1'b1)
		go(16'h0002);
		host.rd(CTL, d);
		`CHK({d[7], o_data_available_pin_n}, 2'b01)
		run_pass(n, f, l);
		`CHK({n[3:0], f}, 8'h11)
		@(negedge i_mclk);
		i_adc_data_rd = 1'b1;
		@(negedge i_mclk);
		i_adc_data_rd = 1'b0;
		host.rd(CTL, d);
		`CHK(d[7], 1'b0)
		go(16'h0000);
		host.rd(CTL, d);
		`CHK(d[7], 1'b1)
		host.wr(CTL, 16'h0000);
		host.rd(CTL, d);
		`CHK({d[7], o_data_available_pin_n}, 2'b01)
	endtask
	task automatic t_cont;
		logic [15:0] d;
		int          k;
		i_chan_enable = 16'h0003;
		host.wr(CTL, 16'h3000);
		for (k = 0; k < 2000 && o_data_available_pin_n; k++) @(negedge i_mclk);
		for (k = 0; k < 300 && !o_data_available_pin_n; k++) @(negedge i_mclk);
		`CHK(k, DAV_PULSE_CYCLES)
		for (k = 0; k < 300 && !o_sample_strobe; k++) @(negedge i_mclk);
		`CHK({o_busy, o_mux_chan}, 5'h10)
		host.rd(CTL, d);
		`CHK(d[7], 1'b0)
		host.wr(CTL, 16'h0000);
		// The pass in progress ends as a single pass, so the flag comes up
		for (k = 0; k < 1000 && o_busy; k++) @(negedge i_mclk);
		`CHK({o_busy, o_data_available_pin_n}, 2'b00)
	endtask
	// Channel 4 is written but not in sync mode, so it must not load
	task automatic t_dac;
		logic [15:0] d;
		i_dac_sync_update_select = 12'h00f;
		i_dac_data_written = 12'h015;
		@(negedge i_mclk);
		i_dac_data_written = 12'h000;
		host.wr(CTL, 16'h2800);
		// The load pulse stands for one cycle only
		@(negedge i_mclk);
		`CHK(o_dac_latch_load, 12'h005)
		host.rd(CTL, d);
		`CHK(d[11], 1'b0)
		host.wr(CTL, 16'h2800);
		@(negedge i_mclk);
		`CHK(o_dac_latch_load, 12'h000)
	endtask
	task automatic t_galarm;
		logic [15:0] d;
		i_alarm_bits = 16'h0100;
		@(negedge i_mclk);
		i_alarm_bits = 16'h0000;
		host.rd(CTL, d);
		`CHK(d[6], 1'b1)
		host.rd(CTL, d);
		`CHK(d[6], 1'b1)
		status_read();
		host.rd(CTL, d);
		`CHK(d[6], 1'b0)
	endtask

	// Main sequence
	initial begin
		repeat (12) @(negedge i_mclk);
		i_rst_n = 1'b1;
		t_reset();
		t_ref_alarm();
		t_config();
		t_single();
		t_cont();
		t_dac();
		t_galarm();
		complete_run();
	end
endmodule // tb

bind conv_ctrl conv_ctrl_chk chk (.i_mclk, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_rd,
	.i_reg_wdata, .o_reg_rdata, .i_alarm_active, .i_chan_enable, .i_dac_sync_update_select,
	.o_dac_latch_load, .o_sample_strobe, .o_busy, .o_int_ref_buf_en, .o_alarm_n,
	.o_data_available_pin_n, .o_sample_rate_select);
